// ---- shared/sil_params.svh ----
// Purpose: Constants for the solenoid interlock lock-control block.
// Assumes: Clock of 250 MHz, a period of 4 ns.
// Notes:   Timing counts are derived from times in their own units.
`ifndef SIL_PARAMS_SVH
`define SIL_PARAMS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SIL_CLK_PERIOD_NS   4
`define SIL_PULSE_US        400
`define SIL_PULSE_CYC       ((`SIL_PULSE_US * 1000) / `SIL_CLK_PERIOD_NS)
`define SIL_TEST_PERIOD_MS  10
`define SIL_TEST_CYC        ((`SIL_TEST_PERIOD_MS * 1000000) / `SIL_CLK_PERIOD_NS)
`define SIL_BOLT_TMO_MS     50
`define SIL_BOLT_CYC        ((`SIL_BOLT_TMO_MS * 1000000) / `SIL_CLK_PERIOD_NS)
`define SIL_FLASH_MS        250
`define SIL_FLASH_CYC       ((`SIL_FLASH_MS * 1000000) / `SIL_CLK_PERIOD_NS)
`define SIL_CNT_W           26

`endif

// ---- shared/sil_pkg.sv ----
// Purpose: Types for the solenoid interlock lock-control block.
// Assumes: Constants come from sil_params.svh.
// Notes:   States and carriers only.
package sil_pkg;

	// ------------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------------
	typedef enum logic [2:0] {
		SIL_ST_POWERON,
		SIL_ST_WAIT_UNLOCK,
		SIL_ST_WAIT_RELOCK,
		SIL_ST_UNLOCKED,
		SIL_ST_DRIVING,
		SIL_ST_LOCKED,
		SIL_ST_FAULT,
		SIL_ST_ESCAPE
	} sil_state_t;

	typedef struct packed {
		logic control_in_first;
		logic control_in_second;
		logic control_in_third;
	} sil_ctrl_t;

	typedef struct packed {
		logic green;
		logic yellow;
		logic red;
	} sil_led_t;

endpackage

// ---- hw/sil_lock_ctrl.sv ----
// Purpose: Lock-control logic of a safety solenoid interlock.
// Assumes: Inputs synchronous to i_clock; bolt sensors already debounced.
// Notes:   Long counts except the test-pulse width are parameters so simulation can shorten them.
// ----------------------------------------------------------------------------
// Overview of operation
// [R1] Unlock when first and second high and third low; otherwise lock.
// [R2] Blocked bolt gets one automatic retry, second failure raises a fault.
// [R3] After a fault, bolt is not driven until control inputs change.
// [R4] Locked at power-on needs unlock then lock before normal locking.
// [R5] Yellow indicator flashes while waiting for that unlock and relock.
// [R6] Each safety output is switched off briefly, at most 0.4 ms, periodically.
// [R7] Monitor uses a 100 ms discrepancy window between channels.
// [R8] Monitor ignores test pulses shorter than 1 ms.
// [R9] Monitor takes two p-type outputs, no cross-short detection needed.
// [R10] Controller uses tested outputs for the highest performance level.
// [R11] Emergency exit switches both outputs off and prevents unintended locking.
// [R12] Active release after turn-back flashes all indicators until inputs driven.
// [R13] Outputs off unless bolt locked and no fault; fault on diagnostic output.
// ----------------------------------------------------------------------------
`include "sil_params.svh"

module sil_lock_ctrl
	import sil_pkg::*;
#(
	parameter int TEST_CYC  = `SIL_TEST_CYC,
	parameter int BOLT_CYC  = `SIL_BOLT_CYC,
	parameter int FLASH_CYC = `SIL_FLASH_CYC
)(
	input  wire logic      i_clock,
	input  wire logic      i_rst_b,
	input  wire sil_ctrl_t i_ctrl,
	input  wire logic      i_bolt_locked,
	input  wire logic      i_escape_active,
	input  wire logic      i_release_active,
	output logic           o_bolt_drive_out,
	output logic           o_safety_out_a,
	output logic           o_safety_out_b,
	output logic           o_diag_fault,
	output sil_led_t       o_led
);

	localparam logic [`SIL_CNT_W-1:0] PULSE_N = `SIL_CNT_W'(`SIL_PULSE_CYC);

	// ------------------------------------------------------------------------
	// Command decode and control state
	// ------------------------------------------------------------------------
	logic            unlock_cmd;
	sil_state_t      state_r,     state_nxt;
	logic            retry_r,     retry_nxt;
	logic [`SIL_CNT_W-1:0] bolt_cnt_r, bolt_cnt_nxt;
	sil_ctrl_t       fault_ctrl_r, fault_ctrl_nxt;
	logic            rel_flag_r,  rel_flag_nxt;
	sil_ctrl_t       ctrl_prev_r;

	// [R1] command decode
	// Covers both wiring variants: third input at ground in each unlock case.
	assign unlock_cmd = i_ctrl.control_in_first & i_ctrl.control_in_second
		& ~i_ctrl.control_in_third;

	// Next-state logic of the bolt sequencer.
	always_comb
	begin
		state_nxt      = state_r;
		retry_nxt      = retry_r;
		bolt_cnt_nxt   = bolt_cnt_r;
		fault_ctrl_nxt = fault_ctrl_r;
		rel_flag_nxt   = rel_flag_r;
		// [R12] release flag set
		// Set wins over clear when both occur in one cycle.
		if (i_release_active)
			rel_flag_nxt = 1'b1;
		else if (i_ctrl != ctrl_prev_r)
			rel_flag_nxt = 1'b0;
		// [R11] emergency exit priority
		// Escape overrides everything; outputs drop and locking is barred.
		if (i_escape_active)
		begin
			state_nxt = SIL_ST_ESCAPE;
		end
		else
		begin
			case (state_r)
				SIL_ST_POWERON:
					// [R4] power-on check
					state_nxt = i_bolt_locked ? SIL_ST_WAIT_UNLOCK : SIL_ST_UNLOCKED;
				SIL_ST_WAIT_UNLOCK:
					if (unlock_cmd)
						state_nxt = SIL_ST_WAIT_RELOCK;
				SIL_ST_WAIT_RELOCK:
					// [R4] relock required
					if (!unlock_cmd && !i_bolt_locked)
						state_nxt = SIL_ST_UNLOCKED;
				SIL_ST_UNLOCKED:
					if (!unlock_cmd)
					begin
						state_nxt    = SIL_ST_DRIVING;
						retry_nxt    = 1'b0;
						bolt_cnt_nxt = '0;
					end
				SIL_ST_DRIVING:
					if (unlock_cmd)
						state_nxt = SIL_ST_UNLOCKED;
					else if (i_bolt_locked)
						state_nxt = SIL_ST_LOCKED;
					else if (bolt_cnt_r == `SIL_CNT_W'(BOLT_CYC - 1))
					begin
						bolt_cnt_nxt = '0;
						// [R2] retry then fault
						if (retry_r)
						begin
							state_nxt      = SIL_ST_FAULT;
							fault_ctrl_nxt = i_ctrl;
						end
						else
							retry_nxt = 1'b1;
					end
					else
						bolt_cnt_nxt = bolt_cnt_r + 1'b1;
				SIL_ST_LOCKED:
					if (unlock_cmd)
						state_nxt = SIL_ST_UNLOCKED;
				SIL_ST_FAULT:
					// [R3] wait input change
					if (i_ctrl != fault_ctrl_r)
						state_nxt = SIL_ST_UNLOCKED;
				SIL_ST_ESCAPE:
					// [R11] no unintended relock
					// Leave only on an unlock command, so a lock level left standing
					// on the inputs cannot drive the bolt straight back out.
					if (unlock_cmd)
						state_nxt = SIL_ST_UNLOCKED;
				default:
					state_nxt = SIL_ST_POWERON;
			endcase
		end
	end

	// Registers of the bolt sequencer.
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			state_r      <= SIL_ST_POWERON;
			retry_r      <= 1'b0;
			bolt_cnt_r   <= '0;
			fault_ctrl_r <= '0;
			rel_flag_r   <= 1'b0;
			ctrl_prev_r  <= '0;
		end
		else
		begin
			state_r      <= state_nxt;
			retry_r      <= retry_nxt;
			bolt_cnt_r   <= bolt_cnt_nxt;
			fault_ctrl_r <= fault_ctrl_nxt;
			rel_flag_r   <= rel_flag_nxt;
			ctrl_prev_r  <= i_ctrl;
		end
	end

	// ------------------------------------------------------------------------
	// Output self-test pulses and indicator blink
	// ------------------------------------------------------------------------
	logic [`SIL_CNT_W-1:0] test_cnt_r,  test_cnt_nxt;
	logic [`SIL_CNT_W-1:0] flash_cnt_r, flash_cnt_nxt;
	logic                  blink_r,     blink_nxt;
	logic                  pulse_a,     pulse_b;
	logic                  outs_ok;

	// Channel B is tested half a period after A so both never drop together.
	always_comb
	begin
		test_cnt_nxt  = (test_cnt_r == `SIL_CNT_W'(TEST_CYC - 1)) ? '0 : test_cnt_r + 1'b1;
		flash_cnt_nxt = flash_cnt_r + 1'b1;
		blink_nxt     = blink_r;
		if (flash_cnt_r == `SIL_CNT_W'(FLASH_CYC - 1))
		begin
			flash_cnt_nxt = '0;
			blink_nxt     = ~blink_r;
		end
	end

	// [R6] test pulse windows
	assign pulse_a = (test_cnt_r < PULSE_N);
	assign pulse_b = (test_cnt_r >= `SIL_CNT_W'(TEST_CYC / 2))
		&& (test_cnt_r < `SIL_CNT_W'(TEST_CYC / 2) + PULSE_N);

	// [R13] output qualification
	assign outs_ok = (state_r == SIL_ST_LOCKED) && i_bolt_locked && !i_escape_active;

	// Test counter and blink registers.
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			// Start just past channel A's dropout, so the first lock after reset
			// is not masked by a test pulse that would carry no information.
			test_cnt_r  <= PULSE_N;
			flash_cnt_r <= '0;
			blink_r     <= 1'b0;
		end
		else
		begin
			test_cnt_r  <= test_cnt_nxt;
			flash_cnt_r <= flash_cnt_nxt;
			blink_r     <= blink_nxt;
		end
	end

	// Registered outputs; the safety outputs take effect one cycle after their cause.
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_bolt_drive_out <= 1'b0;
			o_safety_out_a   <= 1'b0;
			o_safety_out_b   <= 1'b0;
			o_diag_fault     <= 1'b0;
			o_led            <= '0;
		end
		else
		begin
			// [R11] [R3] drive inhibit
			o_bolt_drive_out <= (state_nxt == SIL_ST_DRIVING) || (state_nxt == SIL_ST_LOCKED);
			o_safety_out_a   <= outs_ok && !pulse_a;
			o_safety_out_b   <= outs_ok && !pulse_b;
			// [R13] fault report
			o_diag_fault     <= (state_r == SIL_ST_FAULT);
			if (rel_flag_r)
				// [R12] all flash
				o_led <= '{green: blink_r, yellow: blink_r, red: blink_r};
			else
				// [R5] yellow flash
				o_led <= '{green: outs_ok,
					yellow: ((state_r == SIL_ST_WAIT_UNLOCK)
						|| (state_r == SIL_ST_WAIT_RELOCK)) ? blink_r
						: (state_r == SIL_ST_LOCKED),
					red: (state_r == SIL_ST_FAULT)};
		end
	end

endmodule // sil_lock_ctrl

// ---- dv/sil_lock_ctrl_asserts.sv ----
// Purpose: Port checks for the lock control.
// Assumes: One clock, async active-low reset.
// Notes:   Bound to the block.
module sil_lock_ctrl_asserts
	import sil_pkg::*;
(
	input wire logic      i_clock,
	input wire logic      i_rst_b,
	input wire sil_ctrl_t i_ctrl,
	input wire logic      i_bolt_locked,
	input wire logic      i_escape_active,
	input wire logic      o_bolt_drive_out,
	input wire logic      o_safety_out_a,
	input wire logic      o_safety_out_b,
	input wire logic      o_diag_fault,
	input wire sil_led_t  o_led
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	wire unl = i_ctrl == 3'h6;
	a_open_a_off: assert property (!i_bolt_locked |=> !o_safety_out_a)
		else $error("out a on, bolt open");
	a_open_b_off: assert property (!i_bolt_locked |=> !o_safety_out_b)
		else $error("out b on, bolt open");
	a_fault_outs_off: assert property (o_diag_fault |-> !o_safety_out_a && !o_safety_out_b)
		else $error("out on in fault");
	a_escape_no_drive: assert property (i_escape_active |=> !o_bolt_drive_out)
		else $error("drive in escape");
	a_escape_outs_off: assert property (i_escape_active [*2] |=> !o_safety_out_a && !o_safety_out_b)
		else $error("out on in escape");
	a_fault_no_drive: assert property ($rose(o_diag_fault) |-> !o_bolt_drive_out)
		else $error("drive at fault");
	// Three equal samples, because the fault flag lags its state by one cycle.
	a_fault_held: assert property (o_diag_fault && !i_escape_active && i_ctrl == $past(i_ctrl)
		&& i_ctrl == $past(i_ctrl, 2) |=> o_diag_fault)
		else $error("fault dropped");
	a_unlock_no_drive: assert property (unl |=> !o_bolt_drive_out)
		else $error("drive on unlock");
	c_fault: cover property ($rose(o_diag_fault));
	c_on: cover property ($rose(o_safety_out_a));
	c_escape: cover property (i_escape_active ##1 !o_bolt_drive_out);
endmodule // sil_lock_ctrl_asserts

bind sil_lock_ctrl sil_lock_ctrl_asserts u_chk (.i_clock, .i_rst_b, .i_ctrl, .i_bolt_locked,
	.i_escape_active, .o_bolt_drive_out, .o_safety_out_a, .o_safety_out_b, .o_diag_fault, .o_led);

// ---- dv/sil_bolt_model.sv ----
// Purpose: Bolt and its sensor, and the safety-monitoring module on the outputs.
// Assumes: Bolt starts locked after reset.
// Notes:   A blocked bolt never becomes locked, but one already locked keeps reporting locked.
module sil_bolt_model (
	input  wire logic i_clock,
	input  wire logic i_rst_b,
	input  wire logic i_drive,
	input  wire logic i_unlock,
	input  wire logic i_block,
	output logic      o_locked
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] run_r;
	// Locked after five driven cycles; unlock or escape retracts it.
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			run_r    <= 3'h0;
			o_locked <= 1'b1;
		end
		else
		begin
			run_r <= (i_drive && !i_block) ? run_r + 3'h1 : 3'h0;
			if (i_unlock)
				o_locked <= 1'b0;
			else if (run_r == 3'h5)
				o_locked <= 1'b1;
		end
	end
endmodule // sil_bolt_model

// Dual-channel monitor on the two safety outputs.
module sil_safety_monitor #(
	parameter int BLANK_CYC = 250000,
	parameter int DISC_CYC  = 25000000
)(
	input  wire logic i_clock,
	input  wire logic i_rst_b,
	input  wire logic i_chan_a,
	input  wire logic i_chan_b,
	output logic      o_enabled
);
	timeunit 1ns;
	timeprecision 1ps;
	int   low_a_r, low_b_r, disc_r;
	logic on_a, on_b;
	// pulse blanking
	// A channel counts as off only once it has stayed low for the blanking time.
	assign on_a = i_chan_a || (low_a_r < BLANK_CYC);
	assign on_b = i_chan_b || (low_b_r < BLANK_CYC);
	// dual-channel input
	// Two p-type outputs, no cross-short test: the block pulses its own outputs.
	assign o_enabled = on_a && on_b && (disc_r < DISC_CYC);
	// Low counters start saturated, so both channels read off after reset.
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			low_a_r <= BLANK_CYC;
			low_b_r <= BLANK_CYC;
			disc_r  <= 0;
		end
		else
		begin
			low_a_r <= i_chan_a ? 0 : ((low_a_r < BLANK_CYC) ? low_a_r + 1 : low_a_r);
			low_b_r <= i_chan_b ? 0 : ((low_b_r < BLANK_CYC) ? low_b_r + 1 : low_b_r);
			disc_r  <= (on_a != on_b) ? ((disc_r < DISC_CYC) ? disc_r + 1 : disc_r) : 0;
		end
	end
endmodule // sil_safety_monitor

// ---- dv/sil_lock_ctrl_test.sv ----
// Purpose: Self-checking bench for the lock control.
// Assumes: Short counts; test dropouts fall after the run.
// Notes:   Inputs change at the falling edge.
module sil_lock_ctrl_test;
	import sil_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam sil_ctrl_t LOCK = 3'h0;
	localparam sil_ctrl_t UNL  = 3'h6;
	logic      i_clock = 1'b0, i_rst_b = 1'b0, esc = 1'b0, rel = 1'b0, blk = 1'b0;
	logic      bolt, drv, out_a, out_b, fault, mon_ok;
	// The bench stands for the controller; its outputs count as tested.
	sil_ctrl_t ctrl = LOCK;
	sil_led_t  led;
	int        n_mismatch = 0, n_checks = 0;
	sil_lock_ctrl #(.TEST_CYC(1000000), .BOLT_CYC(50), .FLASH_CYC(8)) u_dut (.i_clock,
		.i_rst_b, .i_ctrl(ctrl), .i_bolt_locked(bolt), .i_escape_active(esc),
		.i_release_active(rel), .o_bolt_drive_out(drv), .o_safety_out_a(out_a),
		.o_safety_out_b(out_b), .o_diag_fault(fault), .o_led(led));
	sil_bolt_model u_bolt (.i_clock, .i_rst_b, .i_drive(drv),
		.i_unlock(ctrl == UNL || esc), .i_block(blk), .o_locked(bolt));
	// The monitor takes the two p-type outputs as one dual-channel input.
	sil_safety_monitor u_mon (.i_clock, .i_rst_b, .i_chan_a(out_a), .i_chan_b(out_b),
		.o_enabled(mon_ok));
	initial
		forever #2 i_clock = ~i_clock;
	task automatic report_and_stop();
		if (n_mismatch == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Bounded wait on one flag; a miss ends the run.
	task automatic wait_for(input int sel, input logic v, input int n);
		logic [4:0] s;
		repeat (n)
		begin
			@(negedge i_clock);
			s = {led == 3'h0, led == 3'h7, led.yellow, fault, out_a};
			if (s[sel] === v)
				return;
		end
		n_mismatch++;
		$display("[ERR] t=%0t got=%h exp=%h", $time, s[sel], v);
		report_and_stop();
	endtask
	task automatic t_poweron();
		repeat (40) @(negedge i_clock);
		chk(out_a, 1'b0);
		chk(mon_ok, 1'b0);
		wait_for(2, 1'b1, 40);
		wait_for(2, 1'b0, 40);
		ctrl = UNL;
		repeat (10) @(negedge i_clock);
		ctrl = LOCK;
		wait_for(0, 1'b1, 200);
		chk({out_b, fault}, 2'h2);
		chk(mon_ok, 1'b1);
	endtask
	// Drive time tells one attempt from two, whether or not it gaps between.
	task automatic t_block();
		int hi;
		hi = 0;
		ctrl = UNL;
		blk = 1'b1;
		repeat (10) @(negedge i_clock);
		ctrl = LOCK;
		repeat (300)
		begin
			@(negedge i_clock);
			hi += drv;
		end
		chk({hi > 75 && hi < 110, fault, drv}, 3'h6);
		blk = 1'b0;
		ctrl = UNL;
		repeat (10) @(negedge i_clock);
		ctrl = LOCK;
		wait_for(0, 1'b1, 200);
		chk(fault, 1'b0);
	endtask
	task automatic t_escape();
		esc = 1'b1;
		repeat (4) @(negedge i_clock);
		chk({out_a, out_b, drv}, 3'h0);
		esc = 1'b0;
		repeat (10) @(negedge i_clock);
		chk({bolt, drv}, 2'h0);
		ctrl = UNL;
		repeat (10) @(negedge i_clock);
	endtask
	task automatic t_release();
		rel = 1'b1;
		wait_for(3, 1'b1, 40);
		wait_for(4, 1'b1, 40);
		rel = 1'b0;
		ctrl = LOCK;
		wait_for(0, 1'b1, 200);
		chk(led, 3'h6);
	endtask
	initial
	begin
		repeat (12) @(negedge i_clock);
		i_rst_b = 1'b1;
		t_poweron();
		t_block();
		t_escape();
		t_release();
		report_and_stop();
	end
endmodule // sil_lock_ctrl_test
